/* File: shared/mem_ctrl_params.svh */
// constants for the static memory wait, float and page timing block
`ifndef MEM_CTRL_PARAMS_SVH
`define MEM_CTRL_PARAMS_SVH
`define WAIT_SEL_OFF     2'b00
`define WAIT_SEL_FROZEN  2'b10
`define WAIT_SEL_READY   2'b11
`define TDF_MODE_PLAIN   1'b0
`define MODE_CS_CTRL     1'b0
`define SLOW_RD_SETUP    11'h001
`define SLOW_RD_PULSE    11'h001
`define SLOW_RD_CS_SETUP 11'h000
`define SLOW_RD_CS_PULSE 11'h002
`define SLOW_RD_CYCLE    11'h002
`define SLOW_WR_SETUP    11'h001
`define SLOW_WR_PULSE    11'h001
`define SLOW_WR_CS_SETUP 11'h000
`define SLOW_WR_CS_PULSE 11'h003
`define SLOW_WR_CYCLE    11'h003
`define SYNC_IDLE        1'b1
`define PAGE_SZ_4        2'h0
`define PAGE_SZ_8        2'h1
`define PAGE_SZ_16       2'h2
`endif

/* File: shared/mem_ctrl_pkg.sv */
// types and field decoders for the static memory timing block
package mem_ctrl_pkg;
  typedef logic [10:0] cnt_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_FLOAT  = 2'b10
  } st_e;

  // setup field: bit 5 weighs 128 cycles
  function automatic cnt_t dec_setup(input logic [5:0] f);
    return {3'h0, f[5], 7'h00} + {6'h00, f[4:0]};
  endfunction : dec_setup

  // pulse field: bit 6 weighs 256 cycles
  function automatic cnt_t dec_pulse(input logic [6:0] f);
    return {2'h0, f[6], 8'h00} + {5'h00, f[5:0]};
  endfunction : dec_pulse

  // cycle field: bit 7 weighs 256 cycles, bit 8 weighs 512
  function automatic cnt_t dec_cycle(input logic [8:0] f);
    return {1'b0, f[8:7], 8'h00} + {4'h0, f[6:0]};
  endfunction : dec_cycle
endpackage : mem_ctrl_pkg

/* File: src/wait_resync.sv */
// two-stage resynchronizer for the external wait input
`include "mem_ctrl_params.svh"
module wait_resync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ext_wait_n,
  output logic      wait_n_sync
);
  logic stage1_r;

  // both stages start deasserted so nothing stalls after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1_r    <= `SYNC_IDLE;
      wait_n_sync <= `SYNC_IDLE;
    end else begin
      stage1_r    <= ext_wait_n;
      wait_n_sync <= stage1_r;
    end
  end
endmodule : wait_resync

/* File: src/page_hit_track.sv */
// remembers the open page and flags hits for page mode reads
`include "mem_ctrl_params.svh"
module page_hit_track (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        take,
  input  wire logic        page_rd,
  input  wire logic [1:0]  cs,
  input  wire logic [23:0] addr,
  input  wire logic [1:0]  size_sel,
  output logic             hit
);
  logic        open_r;
  logic [1:0]  cs_r;
  logic [23:2] page_r;
  logic [2:0]  keep;

  // low address bits inside the page are not compared
  always_comb begin
    keep[0] = (size_sel == `PAGE_SZ_4);
    keep[1] = (size_sel == `PAGE_SZ_4) || (size_sel == `PAGE_SZ_8);
    keep[2] = (size_sel != 2'h3) && !(size_sel > `PAGE_SZ_16);
  end

  assign hit = open_r && page_rd && (cs == cs_r)
            && (addr[23:5] == page_r[23:5])
            && (((addr[4:2] ^ page_r[4:2]) & keep) == 3'h0);

  // any other access closes the page
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      open_r <= 1'b0;
      cs_r   <= 2'h0;
      page_r <= 22'h00_0000;
    end else if (take) begin
      open_r <= page_rd;
      cs_r   <= cs;
      page_r <= addr[23:2];
    end
  end
endmodule : page_hit_track

/* File: src/static_mem_wait_float_page_ctrl.sv */
// access timing with float waits, external wait, slow clock and pages
`include "mem_ctrl_params.svh"
module static_mem_wait_float_page_ctrl
  import mem_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  // access request
  input  wire logic             req_valid,
  input  wire logic             req_write,
  input  wire logic [1:0]       req_cs,
  input  wire logic [23:0]      req_addr,
  output logic                  req_ready,
  output logic                  access_done,
  // per chip select configuration
  input  wire logic [3:0][5:0]  rd_strobe_setup,
  input  wire logic [3:0][6:0]  rd_strobe_pulse,
  input  wire logic [3:0][5:0]  cs_rd_setup,
  input  wire logic [3:0][6:0]  cs_rd_pulse,
  input  wire logic [3:0][8:0]  rd_cycle_len,
  input  wire logic [3:0][5:0]  wr_strobe_setup,
  input  wire logic [3:0][6:0]  wr_strobe_pulse,
  input  wire logic [3:0][5:0]  cs_wr_setup,
  input  wire logic [3:0][6:0]  cs_wr_pulse,
  input  wire logic [3:0][8:0]  wr_cycle_len,
  input  wire logic [3:0]       read_mode,
  input  wire logic [3:0]       write_mode,
  input  wire logic [3:0][3:0]  tdf_cycles,
  input  wire logic [3:0]       tdf_mode,
  input  wire logic [3:0][1:0]  ext_wait_select,
  input  wire logic [3:0]       page_mode_en,
  input  wire logic [3:0][1:0]  page_size_sel,
  // power manager and memory side
  input  wire logic             slow_clk_mode,
  input  wire logic             ext_wait_n,
  output logic [3:0]            chip_select_n,
  output logic                  read_strobe_n,
  output logic                  write_strobe_n,
  output logic [23:0]           mem_addr,
  output logic                  page_hit,
  output logic                  slow_active,
  output logic                  wait_stall
);

  st_e         state_r;
  st_e         state_nxt;
  cnt_t        cnt_r;
  cnt_t        cnt_nxt;
  logic [3:0]  float_r;
  logic [3:0]  float_nxt;

  // parameter set of the access in progress
  cnt_t        s_setup_r;
  cnt_t        s_pulse_r;
  cnt_t        c_setup_r;
  cnt_t        c_pulse_r;
  cnt_t        k_setup_r;
  cnt_t        k_pulse_r;
  cnt_t        cycle_r;
  logic [3:0]  tdf_r;
  logic        write_r;
  logic [1:0]  cs_r;
  logic [1:0]  wait_sel_r;
  logic        slow_r;

  // candidate set for the request on offer
  cnt_t        s_setup_nxt;
  cnt_t        s_pulse_nxt;
  cnt_t        c_setup_nxt;
  cnt_t        c_pulse_nxt;
  cnt_t        k_setup_nxt;
  cnt_t        k_pulse_nxt;
  cnt_t        cycle_nxt;
  cnt_t        k_end;
  cnt_t        hold_len;
  logic [3:0]  tdf_nxt;
  logic [1:0]  wait_sel_nxt;
  logic        ctrl_strobe;
  logic        page_rd;

  logic        take;
  logic        hit;
  logic        wait_n_sync;
  logic        wait_on;
  logic        k_in_pulse;
  logic        k_last;
  logic        freeze;
  logic        last_cycle;
  logic        in_access;
  logic        s_win;
  logic        c_win;
  logic [3:0]  cs_hit;

  // half-open window test on the phase counter
  function automatic logic in_win(input cnt_t c, input cnt_t s,
                                  input cnt_t l);
    return (c >= s) && (c < s + l);
  endfunction : in_win

  wait_resync u_wait_resync (
    .clk         (clk),
    .rst_b       (rst_b),
    .ext_wait_n  (ext_wait_n),
    .wait_n_sync (wait_n_sync)
  );

  assign take    = req_valid && req_ready && (state_r == ST_IDLE);
  assign page_rd = page_mode_en[req_cs] && !req_write
                && !slow_clk_mode;

  page_hit_track u_page_hit_track (
    .clk      (clk),
    .rst_b    (rst_b),
    .take     (take),
    .page_rd  (page_rd),
    .cs       (req_cs),
    .addr     (req_addr),
    .size_sel (page_size_sel[req_cs]),
    .hit      (hit)
  );

  // pick the waveform for the request on offer
  always_comb begin
    s_setup_nxt  = dec_setup(rd_strobe_setup[req_cs]);
    s_pulse_nxt  = dec_pulse(rd_strobe_pulse[req_cs]);
    c_setup_nxt  = dec_setup(cs_rd_setup[req_cs]);
    c_pulse_nxt  = dec_pulse(cs_rd_pulse[req_cs]);
    cycle_nxt    = dec_cycle(rd_cycle_len[req_cs]);
    ctrl_strobe  = read_mode[req_cs];
    wait_sel_nxt = ext_wait_select[req_cs];
    if (req_write) begin
      s_setup_nxt = dec_setup(wr_strobe_setup[req_cs]);
      s_pulse_nxt = dec_pulse(wr_strobe_pulse[req_cs]);
      c_setup_nxt = dec_setup(cs_wr_setup[req_cs]);
      c_pulse_nxt = dec_pulse(cs_wr_pulse[req_cs]);
      cycle_nxt   = dec_cycle(wr_cycle_len[req_cs]);
      ctrl_strobe = write_mode[req_cs];
    end
    if (slow_clk_mode && req_write) begin
      s_setup_nxt  = `SLOW_WR_SETUP;
      s_pulse_nxt  = `SLOW_WR_PULSE;
      c_setup_nxt  = `SLOW_WR_CS_SETUP;
      c_pulse_nxt  = `SLOW_WR_CS_PULSE;
      cycle_nxt    = `SLOW_WR_CYCLE;
      wait_sel_nxt = `WAIT_SEL_OFF;
    end else if (slow_clk_mode) begin
      s_setup_nxt  = `SLOW_RD_SETUP;
      s_pulse_nxt  = `SLOW_RD_PULSE;
      c_setup_nxt  = `SLOW_RD_CS_SETUP;
      c_pulse_nxt  = `SLOW_RD_CS_PULSE;
      cycle_nxt    = `SLOW_RD_CYCLE;
      wait_sel_nxt = `WAIT_SEL_OFF;
    end else if (page_rd) begin
      // both strobes low for the whole access, one length for all
      c_pulse_nxt  = hit ? dec_pulse(rd_strobe_pulse[req_cs])
                         : dec_pulse(cs_rd_pulse[req_cs]);
      s_setup_nxt  = 11'h000;
      c_setup_nxt  = 11'h000;
      s_pulse_nxt  = c_pulse_nxt;
      cycle_nxt    = c_pulse_nxt;
      wait_sel_nxt = `WAIT_SEL_OFF;
    end
    // wait and float follow the signal that controls the access
    if (ctrl_strobe == `MODE_CS_CTRL) begin
      k_setup_nxt = c_setup_nxt;
      k_pulse_nxt = c_pulse_nxt;
    end else begin
      k_setup_nxt = s_setup_nxt;
      k_pulse_nxt = s_pulse_nxt;
    end
    k_end    = k_setup_nxt + k_pulse_nxt;
    hold_len = (cycle_nxt > k_end) ? cycle_nxt - k_end : 11'h000;
    // hold cycles already spent count against the float period
    if (req_write || page_rd || slow_clk_mode
        || tdf_mode[req_cs] != `TDF_MODE_PLAIN) begin
      tdf_nxt = 4'h0;
    end else if ({7'h00, tdf_cycles[req_cs]} > hold_len) begin
      tdf_nxt = tdf_cycles[req_cs] - hold_len[3:0];
    end else begin
      tdf_nxt = 4'h0;
    end
  end

  // latch the set at acceptance so a mode change mid-transfer is ignored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_setup_r  <= 11'h000;
      s_pulse_r  <= 11'h000;
      c_setup_r  <= 11'h000;
      c_pulse_r  <= 11'h000;
      k_setup_r  <= 11'h000;
      k_pulse_r  <= 11'h000;
      cycle_r    <= 11'h000;
      tdf_r      <= 4'h0;
      write_r    <= 1'b0;
      cs_r       <= 2'h0;
      wait_sel_r <= `WAIT_SEL_OFF;
      slow_r     <= 1'b0;
    end else if (take) begin
      s_setup_r  <= s_setup_nxt;
      s_pulse_r  <= s_pulse_nxt;
      c_setup_r  <= c_setup_nxt;
      c_pulse_r  <= c_pulse_nxt;
      k_setup_r  <= k_setup_nxt;
      k_pulse_r  <= k_pulse_nxt;
      cycle_r    <= cycle_nxt;
      tdf_r      <= tdf_nxt;
      write_r    <= req_write;
      cs_r       <= req_cs;
      wait_sel_r <= wait_sel_nxt;
      slow_r     <= slow_clk_mode;
    end
  end

  // address and page status stay up until the next acceptance
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_addr <= 24'h00_0000;
      page_hit <= 1'b0;
    end else if (take) begin
      mem_addr <= req_addr;
      page_hit <= hit;
    end
  end

  // wait handling, only inside the controlling pulse
  assign in_access  = (state_r == ST_ACCESS);
  assign wait_on    = !wait_n_sync;
  assign k_in_pulse = in_win(cnt_r, k_setup_r, k_pulse_r);
  assign k_last     = k_in_pulse
                   && (cnt_r == k_setup_r + k_pulse_r - 11'h001);

  always_comb begin
    case (wait_sel_r)
      `WAIT_SEL_FROZEN: freeze = in_access && k_in_pulse
                              && wait_on;
      `WAIT_SEL_READY:  freeze = in_access && k_last
                              && wait_on;
      default:          freeze = 1'b0;
    endcase
  end

  // zero cycle length still runs one cycle
  assign last_cycle = (cnt_r + 11'h001 >= cycle_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    float_nxt = float_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_ACCESS;
          cnt_nxt   = 11'h000;
        end
      end
      ST_ACCESS: begin
        if (freeze) begin
          cnt_nxt = cnt_r;
        end else if (last_cycle) begin
          float_nxt = tdf_r;
          state_nxt = (tdf_r != 4'h0) ? ST_FLOAT : ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      ST_FLOAT: begin
        // next access waits until the bus is released
        float_nxt = float_r - 4'h1;
        if (float_r == 4'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= 11'h000;
      float_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      float_r <= float_nxt;
    end
  end

  // handshake flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_ready   <= 1'b0;
      access_done <= 1'b0;
    end else begin
      // ready drops as a request is taken, so no second take slips in
      req_ready   <= (state_nxt == ST_IDLE) && !take;
      access_done <= in_access && !freeze && last_cycle;
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_stall  <= 1'b0;
      slow_active <= 1'b0;
    end else begin
      wait_stall  <= freeze;
      slow_active <= slow_clk_mode;
    end
  end

  // memory strobes, one cycle behind the phase counter; a frozen
  // counter keeps every strobe where it is
  assign s_win = in_access && in_win(cnt_r, s_setup_r, s_pulse_r);
  assign c_win = in_access && in_win(cnt_r, c_setup_r, c_pulse_r);

  // one decode per chip select line
  for (genvar g = 0; g < 4; g++) begin : g_cs_hit
    assign cs_hit[g] = c_win && (cs_r == 2'(g));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      read_strobe_n  <= !(s_win && !write_r);
      write_strobe_n <= !(s_win && write_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chip_select_n <= 4'hf;
    end else begin
      chip_select_n <= ~cs_hit;
    end
  end

endmodule : static_mem_wait_float_page_ctrl

/* File: bench/ext_mem_model.sv */
// memory side model that answers a strobe with the wait line
module ext_mem_model (
  input  wire logic       clk,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [4:0] wait_lat,
  input  wire logic [4:0] wait_len,
  output logic            ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act;
  logic act_q = 1'b0;
  int   cnt   = 99;

  assign act = !(read_strobe_n && write_strobe_n);

  // count from the strobe fall; saturate so a stale window never reopens
  always @(posedge clk) begin
    act_q <= act;
    if (act && !act_q) begin
      cnt <= 0;
    end else if (cnt < 99) begin
      cnt <= cnt + 1;
    end
  end

  // line is pulled up, so a released wait reads as deasserted
  assign ext_wait_n = !(cnt >= int'(wait_lat) &&
                        cnt < int'(wait_lat) + int'(wait_len));
endmodule : ext_mem_model

/* File: bench/static_mem_ctrl_monitor.sv */
// concurrent checks on the static memory timing block ports
module static_mem_ctrl_monitor (
  input wire logic            clk,
  input wire logic            rst_b,
  input wire logic            req_ready,
  input wire logic [3:0][1:0] ext_wait_select,
  input wire logic            slow_active,
  input wire logic            ext_wait_n,
  input wire logic [3:0]      chip_select_n,
  input wire logic            read_strobe_n,
  input wire logic            write_strobe_n,
  input wire logic            wait_stall
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_slow_read: assert property (
    $fell(read_strobe_n) && slow_active |-> (chip_select_n != 4'hf)
    ##1 (read_strobe_n && chip_select_n == 4'hf))
    else $error("slow read waveform wrong");
  chk_slow_write: assert property (
    $fell(write_strobe_n) && slow_active |-> (chip_select_n != 4'hf)
    ##1 (write_strobe_n && chip_select_n != 4'hf) ##1 (chip_select_n == 4'hf))
    else $error("slow write waveform wrong");
  chk_frozen_hold: assert property (
    wait_stall && $past(wait_stall) |-> $stable(chip_select_n) &&
    $stable(read_strobe_n) && $stable(write_strobe_n))
    else $error("outputs moved during stall");
  chk_wait_off: assert property (
    (ext_wait_select & 8'haa) == 8'h00 |-> !wait_stall)
    else $error("stall with wait disabled");
  chk_sync_delay: assert property (
    wait_stall |-> !$past(ext_wait_n, 2) || !$past(ext_wait_n, 3) ||
    !$past(ext_wait_n, 4))
    else $error("stall without resynchronized wait");
  chk_stall_pulse: assert property (
    wait_stall |-> !read_strobe_n || !write_strobe_n ||
    chip_select_n != 4'hf)
    else $error("stall outside pulse");
  chk_slow_nowait: assert property (
    slow_active |-> !wait_stall)
    else $error("stall in slow clock mode");
  chk_idle_nowait: assert property (
    req_ready |-> !wait_stall)
    else $error("stall while idle");
endmodule : static_mem_ctrl_monitor

bind static_mem_wait_float_page_ctrl static_mem_ctrl_monitor mon (.*);

/* File: bench/static_mem_wait_float_page_ctrl_bench.sv */
// self-checking bench for the static memory timing block
module static_mem_wait_float_page_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst_b, req_valid, req_write, req_ready;
  logic             access_done, slow_clk_mode, ext_wait_n;
  logic             read_strobe_n, write_strobe_n;
  logic             page_hit, slow_active, wait_stall;
  logic [1:0]       req_cs;
  logic [23:0]      req_addr, mem_addr, b, z, a;
  logic [3:0][5:0]  rd_strobe_setup, cs_rd_setup;
  logic [3:0][5:0]  wr_strobe_setup, cs_wr_setup;
  logic [3:0][6:0]  rd_strobe_pulse, cs_rd_pulse;
  logic [3:0][6:0]  wr_strobe_pulse, cs_wr_pulse;
  logic [3:0][8:0]  rd_cycle_len, wr_cycle_len;
  logic [3:0]       read_mode, write_mode, tdf_mode;
  logic [3:0]       page_mode_en, chip_select_n;
  logic [3:0][3:0]  tdf_cycles;
  logic [3:0][1:0]  ext_wait_select, page_size_sel;
  logic [4:0]       wait_lat, wait_len;
  logic [1:0]       ws[6] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1};
  int               wa[6] = '{1, 1, 1, 10, 1, 1};
  int               wn[6] = '{4, 2, 12, 4, 12, 12};
  int               es[6] = '{4, 0, 10, 0, 0, 0};
  int               fv[4] = '{2, 6, 15, 15};
  int               num_errors, tests_run, lat, st, rl, wl, cl, gp, g0, e;

  static_mem_wait_float_page_ctrl dut (.*);
  ext_mem_model mem (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] ex, sn);
    tests_run++;
    if (ex !== sn) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, ex, sn);
    end
  endtask : chk

  // one access, then the idle gap until the next may be taken
  task automatic acc(input logic w, input logic [1:0] c,
                     input logic [23:0] ad, input logic drop);
    req_write = w;
    req_cs = c;
    req_addr = ad;
    req_valid = 1'b1;
    @(posedge clk);
    #5 req_valid = 1'b0;
    if (drop) slow_clk_mode = 1'b0;
    {lat, st, rl, wl, cl, gp} = '0;
    while (access_done !== 1'b1 && lat < 300) begin
      @(posedge clk);
      #1 lat++;
      st += wait_stall;
      rl += !read_strobe_n;
      wl += !write_strobe_n;
      cl += chip_select_n != 4'hf;
    end
    #4;
    while (req_ready !== 1'b1 && gp < 60) begin
      @(posedge clk);
      #5 gp++;
    end
  endtask : acc

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    {num_errors, tests_run} = '0;
    {rst_b, req_valid, req_write, req_cs, req_addr} = '0;
    {slow_clk_mode, wait_lat, wait_len} = '0;
    rd_strobe_setup = {4{6'h01}};
    wr_strobe_setup = {4{6'h01}};
    {cs_rd_setup, cs_wr_setup, tdf_mode, tdf_cycles} = '0;
    rd_strobe_pulse = {4{7'h08}};
    wr_strobe_pulse = {4{7'h08}};
    cs_rd_pulse = {4{7'h0a}};
    cs_wr_pulse = {4{7'h0a}};
    rd_cycle_len = {4{9'h00b}}; // two hold cycles, pulse 8
    wr_cycle_len = {4{9'h00b}};
    {read_mode, write_mode} = '1;
    {ext_wait_select, page_mode_en, page_size_sel} = '0;
    repeat (8) @(posedge clk);
    #5 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #5;
    acc(1'b0, 2'h0, '0, 1'b0);
    chk("read_len", 11, lat);
    chk("first_stall", 0, st);
    g0 = gp;
    acc(1'b1, 2'h0, '0, 1'b0);
    chk("write_low", 8, wl);
    for (int i = 0; i < 4; i++) begin
      tdf_cycles[0] = 4'(fv[i]);
      tdf_mode[0] = i == 3;
      acc(1'b0, 2'h0, '0, 1'b0);
      e = (i < 3 && fv[i] > 2) ? fv[i] - 2 : 0;
      chk("float_gap", g0 + e, gp);
    end
    {tdf_cycles, tdf_mode} = '0;
    $display("end of test float");
    for (int i = 0; i < 6; i++) begin
      ext_wait_select[0] = ws[i];
      wait_lat = 5'(wa[i]);
      wait_len = 5'(wn[i]);
      acc(i == 0, 2'h0, '0, 1'b0);
      e = es[i];
      if (i == 2) chk("ready_stall", 1, st > 0);
      chk("stall_cycles", e, st);
      chk("wait_len", 11 + e, lat);
      if (i == 0) chk("frozen_low", 12, wl);
    end
    $display("end of test wait");
    slow_clk_mode = 1'b1;
    ext_wait_select[2] = 2'h2;
    wait_lat = 5'h00;
    wait_len = 5'h08;
    acc(1'b0, 2'h2, '0, 1'b0);
    chk("slow_rd_len", 2, lat);
    chk("slow_rd_low", 1, rl);
    chk("slow_rd_cs", 2, cl);
    chk("slow_stall", 0, st);
    for (int d = 0; d < 2; d++) begin
      acc(1'b1, 2'h2, '0, d == 1);
      chk("slow_wr_len", 3, lat);
      chk("slow_wr_low", 1, wl);
      chk("slow_wr_cs", 3, cl);
      chk("slow_active", d == 0, slow_active);
    end
    {wait_len, ext_wait_select} = '0;
    $display("end of test slow");
    page_mode_en[1] = 1'b1;
    cs_rd_pulse[1] = 7'h09;
    rd_strobe_pulse[1] = 7'h03;
    for (int s = 0; s < 4; s++) begin
      page_size_sel[1] = 2'(s);
      z = 24'h00_0004 << s;
      b = 24'(128 * (s + 1));
      for (int j = 0; j < 4; j++) begin
        a = j == 0 ? '0 : j == 1 ? z - 1 : j == 2 ? z : z + 24'h80_0000;
        e = j == 1 ? 3 : 9;
        acc(1'b0, 2'h1, b + a, 1'b0);
        chk("page_len", e, lat);
        chk("page_low", e, rl);
        chk("page_hit", j == 1, page_hit);
        chk("mem_addr", b + a, mem_addr);
      end
    end
    acc(1'b1, 2'h0, '0, 1'b0);
    acc(1'b0, 2'h1, b + a, 1'b0);
    chk("gap_page_len", 9, lat);
    chk("gap_page_hit", 0, page_hit);
    $display("end of test page");
    end_sim();
  end
endmodule : static_mem_wait_float_page_ctrl_bench
